//--- design/alu_core_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef ALU_CORE_REGS_VH
`define ALU_CORE_REGS_VH
`define OFS_CMD 8'h00
`define OFS_OPA 8'h04
`define OFS_OPB 8'h08
`define OFS_RES 8'h0C
`define OFS_RESHI 8'h10
`define OFS_FLAGS 8'h14
`define OFS_CORE 8'h18
`define OFS_WREG0 8'h1C
`define OFS_WREG1 8'h20
`define OFS_ADDR 8'h24
`define OFS_STAT 8'h28
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_OV 2
`define FLAG_N 3
`define FLAG_PL_LO 5
`define FLAG_DC 8
`define CORE_PSV 2
`define CORE_UPL 3
`define FLAGS_RESET 16'h0000
`define CORE_RESET 16'h0004
`define OP_ADD 4'h0
`define OP_SUB 4'h1
`define OP_AND 4'h2
`define OP_IOR 4'h3
`define OP_XOR 4'h4
`define OP_SHL 4'h5
`define OP_LSR 4'h6
`define OP_ASR 4'h7
`define OP_MUL 4'h8
`define OP_DIV 4'h9
`define OP_RDMEM 4'hA
`define MUL_SS 3'h0
`define MUL_UU 3'h1
`define MUL_US 3'h2
`define MUL_SL 3'h3
`define MUL_UL 3'h4
`define MUL_BB 3'h5
`define DIV_CYCLES 5'd19
`define WINDOW_BASE 16'h8000
`endif

//--- design/cpu_alu_status_multiply.v
// ALU, flag register, core control and multiply/divide datapath
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "alu_core_regs.vh"
module cpu_alu_status_multiply (
   input wire clk,
   input wire rst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [15:0] memData,
   output reg [15:0] memAddr,
   output reg memRead,
   output reg windowMapped,
   output reg addrTrap,
   output reg [3:0] cpuPriorityLevel
);
   reg [15:0] flags;
   reg [15:0] coreCtl;
   reg [15:0] opA;
   reg [15:0] opB;
   reg [15:0] result;
   reg [15:0] resultHi;
   reg [15:0] workingReg0;
   reg [15:0] workingReg1;
   reg [15:0] cmd;
   reg busy;
   reg [4:0] divCount;
   reg [31:0] divRem;
   reg [15:0] divQuo;
   reg divNeg;
   reg divRemNeg;
   reg awHeld;
   reg wHeld;
   reg [7:0] awAddr;
   reg [31:0] wData;
   reg [3:0] wStrb;
   reg startPulse;
   reg abortPulse;

   // Command word: [3:0] op, [4] byte mode, [5] operand B from memory,
   // [8:6] multiply mode, [9] signed divide, [14:10] literal
   wire [3:0] op = cmd[3:0];
   wire byteMode = cmd[4];
   wire srcMem = cmd[5];
   wire [2:0] mulMode = cmd[8:6];
   wire divSigned = cmd[9];
   wire [4:0] literal = cmd[14:10];
   wire [15:0] bVal = srcMem ? memData : opB;

   function [15:0] sext8;
      input [15:0] v;
      begin
         sext8 = {{8{v[7]}}, v[7:0]};
      end
   endfunction

   // ALU result and flag inputs
   reg [16:0] sum;
   reg [4:0] nib;
   reg [15:0] aluOut;
   reg carry;
   reg dcarry;
   reg ovf;
   reg arith;
   reg [15:0] bEff;
   always @* begin
      bEff = (op == `OP_SUB) ? ~bVal : bVal;
      sum = {1'b0, opA} + {1'b0, bEff} + {16'h0000, op == `OP_SUB};
      nib = {1'b0, opA[3:0]} + {1'b0, bEff[3:0]} + {4'h0, op == `OP_SUB};
      aluOut = 16'h0000;
      carry = flags[`FLAG_C];
      dcarry = flags[`FLAG_DC];
      ovf = 1'b0;
      arith = 1'b0;
      case (op)
         `OP_ADD, `OP_SUB: begin
            arith = 1'b1;
            aluOut = sum[15:0];
            if (byteMode) begin
               carry = opA[8] ^ bEff[8] ^ sum[8];
               dcarry = nib[4];
               ovf = (opA[7] == bEff[7]) && (sum[7] != opA[7]);
            end else begin
               carry = sum[16];
               dcarry = opA[8] ^ bEff[8] ^ sum[8];
               ovf = (opA[15] == bEff[15]) && (sum[15] != opA[15]);
            end
         end
         `OP_AND: aluOut = opA & bVal;
         `OP_IOR: aluOut = opA | bVal;
         `OP_XOR: aluOut = opA ^ bVal;
         `OP_SHL: begin
            aluOut = {opA[14:0], 1'b0};
            carry = byteMode ? opA[7] : opA[15];
         end
         `OP_LSR: begin
            aluOut = byteMode ? {9'h000, opA[7:1]} : {1'b0, opA[15:1]};
            carry = opA[0];
         end
         `OP_ASR: begin
            aluOut = byteMode ? {8'h00, opA[7], opA[7:1]}
                              : {opA[15], opA[15:1]};
            carry = opA[0];
         end
         default: aluOut = 16'h0000;
      endcase
      if (byteMode)
         aluOut = {8'h00, aluOut[7:0]};
   end
   wire resNeg = byteMode ? aluOut[7] : aluOut[15];

   // 17x17 multiplier, single cycle
   reg [16:0] mulA;
   reg [16:0] mulB;
   always @* begin
      case (mulMode)
         `MUL_SS: {mulA, mulB} = {opA[15], opA, bVal[15], bVal};
         `MUL_UU: {mulA, mulB} = {1'b0, opA, 1'b0, bVal};
         `MUL_US: {mulA, mulB} = {1'b0, opA, bVal[15], bVal};
         `MUL_SL: {mulA, mulB} = {opA[15], opA, 12'h000, literal};
         `MUL_UL: {mulA, mulB} = {1'b0, opA, 12'h000, literal};
         `MUL_BB: {mulA, mulB} = {9'h000, opA[7:0], 9'h000, bVal[7:0]};
         default: {mulA, mulB} = 34'h0;
      endcase
   end
   wire signed [33:0] product = $signed(mulA) * $signed(mulB);

   // Restoring style divide on magnitudes, one bit per cycle
   wire [15:0] absA = (divSigned && opA[15]) ? (16'h0000 - opA) : opA;
   wire [15:0] absB = (divSigned && opB[15]) ? (16'h0000 - opB) : opB;
   // Divisor magnitude is read live, so OPB must stay put while busy
   wire [16:0] trial = {1'b0, divRem[30:15]} - {1'b0, absB};

   // Bus slave: address and data may arrive in either order
   wire wrFire = awHeld && wHeld && !s_axi_bvalid;
   always @(posedge clk) begin
      if (rst) begin
         {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready} <= 4'h0;
         {s_axi_rvalid, s_axi_bresp, s_axi_rresp} <= 5'h00;
         s_axi_rdata <= 32'h00000000;
         {awHeld, wHeld} <= 2'b00;
         awAddr <= 8'h00;
         wData <= 32'h00000000;
         wStrb <= 4'h0;
         {opA, opB} <= 32'h00000000;
         cmd <= 16'h0000;
         coreCtl <= `CORE_RESET;
         memAddr <= 16'h0000;
         {startPulse, abortPulse, memRead, addrTrap} <= 4'h0;
      end else begin
         startPulse <= 1'b0;
         abortPulse <= 1'b0;
         memRead <= 1'b0;
         s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            case (awAddr)
               `OFS_CMD: begin
                  if (wStrb[1:0] == 2'b11 && !busy) begin
                     cmd <= wData[15:0];
                     startPulse <= 1'b1;
                  end
               end
               `OFS_OPA: if (wStrb[1:0] == 2'b11) opA <= wData[15:0];
               `OFS_OPB: if (wStrb[1:0] == 2'b11) opB <= wData[15:0];
               // Both low byte lanes must be written; a partial one is ignored
               `OFS_CORE: if (wStrb[1:0] == 2'b11)
                  coreCtl <= {12'h000, coreCtl[`CORE_UPL] & wData[3],
                              wData[2], 2'b00};
               `OFS_ADDR: begin
                  if (wStrb[1:0] == 2'b11) begin
                     memAddr <= wData[15:0];
                     memRead <= wData[15:0] < `WINDOW_BASE
                                || coreCtl[`CORE_PSV];
                     addrTrap <= wData[15:0] >= `WINDOW_BASE
                                 && !coreCtl[`CORE_PSV];
                  end
               end
               `OFS_STAT: if (wStrb[0] && wData[0]) abortPulse <= 1'b1;
               `OFS_FLAGS, `OFS_RES, `OFS_RESHI, `OFS_WREG0,
               `OFS_WREG1: s_axi_bresp <= 2'b00;
               default: s_axi_bresp <= 2'b10;
            endcase
         end else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
               `OFS_CMD: s_axi_rdata <= {16'h0000, cmd};
               `OFS_OPA: s_axi_rdata <= {16'h0000, opA};
               `OFS_OPB: s_axi_rdata <= {16'h0000, opB};
               `OFS_RES: s_axi_rdata <= {16'h0000, result};
               `OFS_RESHI: s_axi_rdata <= {16'h0000, resultHi};
               `OFS_FLAGS: s_axi_rdata <= {16'h0000, flags};
               `OFS_CORE: s_axi_rdata <= {16'h0000, coreCtl};
               `OFS_WREG0: s_axi_rdata <= {16'h0000, workingReg0};
               `OFS_WREG1: s_axi_rdata <= {16'h0000, workingReg1};
               `OFS_ADDR: s_axi_rdata <= {16'h0000, memAddr};
               `OFS_STAT: s_axi_rdata <= {30'h00000000, addrTrap, busy};
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'b10;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Execution: one cycle for ALU and multiply, 19 for divide
   always @(posedge clk) begin
      if (rst) begin
         flags <= `FLAGS_RESET;
         {result, resultHi} <= 32'h00000000;
         {workingReg0, workingReg1} <= 32'h00000000;
         busy <= 1'b0;
         divCount <= 5'd0;
         divRem <= 32'h00000000;
         divQuo <= 16'h0000;
         {divNeg, divRemNeg} <= 2'b00;
      end else if (busy) begin
         // Abort between cycles leaves registers as they were
         if (abortPulse) begin
            busy <= 1'b0;
         end else if (divCount > 5'd3) begin
            divCount <= divCount - 5'd1;
            if (!trial[16]) begin
               divRem <= {trial[15:0], divRem[14:0], 1'b0};
               divQuo <= {divQuo[14:0], 1'b1};
            end else begin
               divRem <= {divRem[30:0], 1'b0};
               divQuo <= {divQuo[14:0], 1'b0};
            end
         end else if (divCount != 5'd1) begin
            divCount <= divCount - 5'd1;
         end else begin
            busy <= 1'b0;
            workingReg0 <= divNeg ? 16'h0000 - divQuo : divQuo;
            workingReg1 <= divRemNeg ? 16'h0000 - divRem[31:16]
                                     : divRem[31:16];
            flags[`FLAG_Z] <= divQuo == 16'h0000;
            flags[`FLAG_N] <= divNeg && divQuo != 16'h0000;
         end
      end else if (startPulse) begin
         if (op == `OP_DIV) begin
            busy <= 1'b1;
            divCount <= `DIV_CYCLES;
            divRem <= {16'h0000, absA};
            divQuo <= 16'h0000;
            divNeg <= divSigned && (opA[15] ^ opB[15]);
            divRemNeg <= divSigned && opA[15];
         end else if (op == `OP_MUL) begin
            result <= product[15:0];
            resultHi <= product[31:16];
         end else if (op == `OP_RDMEM) begin
            result <= byteMode ? sext8(memData) : memData;
         end else begin
            result <= aluOut;
            flags[`FLAG_N] <= resNeg;
            if (aluOut != 16'h0000)
               flags[`FLAG_Z] <= 1'b0;
            else if (!arith)
               flags[`FLAG_Z] <= 1'b1;
            flags[`FLAG_C] <= carry;
            if (arith) begin
               flags[`FLAG_OV] <= ovf;
               flags[`FLAG_DC] <= dcarry;
            end
         end
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         windowMapped <= 1'b0;
         cpuPriorityLevel <= 4'h0;
      end else begin
         windowMapped <= coreCtl[`CORE_PSV];
         cpuPriorityLevel <= {coreCtl[`CORE_UPL], flags[7:`FLAG_PL_LO]};
      end
   end
endmodule // cpu_alu_status_multiply

//--- testbench/cpu_alu_status_multiply_chk.sv
// Port-level assertions for the ALU core register block
`timescale 1ns/1ps
`include "alu_core_regs.vh"
module cpu_alu_status_multiply_chk (
   input logic clk,
   input logic rst,
   input logic [7:0] s_axi_araddr,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic [1:0] s_axi_rresp,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic [15:0] memAddr,
   input logic memRead,
   input logic windowMapped,
   input logic addrTrap,
   input logic [3:0] cpuPriorityLevel
);
   logic [7:0] rdAddr;
   logic coreRd;
   logic flagRd;
   // Remember which register the answer on the read channel belongs to
   always @(posedge clk) begin
      if (rst)
         rdAddr <= 8'h00;
      else if (s_axi_arvalid && s_axi_arready)
         rdAddr <= s_axi_araddr;
   end
   assign coreRd = s_axi_rvalid && rdAddr == `OFS_CORE;
   assign flagRd = s_axi_rvalid && rdAddr == `OFS_FLAGS;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read answer missing");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read answer withdrawn");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid) else $error("write answer withdrawn");
   a_core_unused_zero: assert property (
      coreRd |-> s_axi_rdata[31:4] == 28'h0 && s_axi_rdata[1:0] == 2'h0)
      else $error("unused control bits not zero");
   a_upper_level_bit: assert property (
      coreRd |-> s_axi_rdata[3] == cpuPriorityLevel[3])
      else $error("upper priority bit mismatch");
   a_level_low_bits: assert property (
      flagRd |-> s_axi_rdata[7:5] == cpuPriorityLevel[2:0])
      else $error("priority level low bits mismatch");
   a_window_bit: assert property (
      coreRd |-> s_axi_rdata[2] == windowMapped)
      else $error("window enable mismatch");
   a_trap_cause: assert property (
      $rose(addrTrap) |-> !windowMapped && memAddr >= `WINDOW_BASE)
      else $error("trap without cause");
   a_read_allowed: assert property (
      memRead |-> memAddr < `WINDOW_BASE || windowMapped)
      else $error("upper read while window off");
   a_read_pulse: assert property (memRead |=> !memRead)
      else $error("memory read longer than a pulse");
   cover property ($rose(addrTrap));
   cover property (memRead && memAddr >= `WINDOW_BASE);
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // cpu_alu_status_multiply_chk
bind cpu_alu_status_multiply cpu_alu_status_multiply_chk
   u_cpu_alu_status_multiply_chk (.clk(clk), .rst(rst),
   .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .memAddr(memAddr), .memRead(memRead),
   .windowMapped(windowMapped), .addrTrap(addrTrap),
   .cpuPriorityLevel(cpuPriorityLevel));

//--- testbench/test_cpu_alu_status_multiply.sv
// Register-level bench for the ALU core register block
`timescale 1ns/1ps
`include "alu_core_regs.vh"
module test_cpu_alu_status_multiply;
   logic clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready, memRead, windowMapped, addrTrap;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, num_errors, checked, memReads;
   logic [3:0] s_axi_wstrb, cpuPriorityLevel;
   logic [1:0] s_axi_bresp, s_axi_rresp, lastResp, wrResp;
   logic [15:0] memData, memAddr;
   logic lateReady;
   cpu_alu_status_multiply u_cpu_alu_status_multiply (.clk(clk), .rst(rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .memData(memData), .memAddr(memAddr),
      .memRead(memRead), .windowMapped(windowMapped), .addrTrap(addrTrap),
      .cpuPriorityLevel(cpuPriorityLevel));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      if (memRead === 1'b1)
         memReads <= memReads + 32'h1;
   end
   task automatic finish_test;
      begin
         if (num_errors == 32'h0 && checked > 32'h0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      begin
         checked = checked + 32'h1;
         if (got !== exp) begin
            num_errors = num_errors + 32'h1;
            $display("unexpected at %0t: got %h expected %h", $time, got,
               exp);
         end
      end
   endtask
   // Entering on a fresh edge keeps bready and rready from being set twice
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      begin
         @(posedge clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= !lateReady;
         do begin
            @(posedge clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1 && s_axi_bready !== 1'b1)
               s_axi_bready <= 1'b1;
         end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
         wrResp = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      begin
         @(posedge clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= !lateReady;
         do begin
            @(posedge clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1 && s_axi_rready !== 1'b1)
               s_axi_rready <= 1'b1;
         end while (s_axi_rvalid !== 1'b1 || s_axi_rready !== 1'b1);
         v = s_axi_rdata;
         lastResp = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
      input logic [31:0] m);
      logic [31:0] v;
      begin
         rd(a, v);
         check(v & m, exp & m);
      end
   endtask
   task automatic alu(input logic [15:0] c, input logic [15:0] a,
      input logic [15:0] b, input logic [31:0] res, input logic [31:0] m);
      begin
         wr(`OFS_OPA, {16'h0, a});
         wr(`OFS_OPB, {16'h0, b});
         wr(`OFS_CMD, {16'h0, c});
         rdChk(`OFS_RES, res, m);
      end
   endtask
   task automatic divRun(input logic [15:0] c, input logic [15:0] a,
      input logic [15:0] b, input logic [31:0] q, input logic [31:0] r);
      logic [31:0] v;
      integer k;
      begin
         wr(`OFS_OPA, {16'h0, a});
         wr(`OFS_OPB, {16'h0, b});
         wr(`OFS_CMD, {16'h0, c});
         rd(`OFS_STAT, v);
         check(v & 32'h1, 32'h1);
         k = 0;
         // Each poll costs about four cycles, so eight polls outlast 19
         while (v[0] !== 1'b0 && k < 8) begin
            rd(`OFS_STAT, v);
            k = k + 1;
         end
         check(v & 32'h1, 32'h0);
         rdChk(`OFS_WREG0, q, 32'hFFFFFFFF);
         rdChk(`OFS_WREG1, r, 32'hFFFFFFFF);
      end
   endtask
   initial begin
      #(40 * 20000);
      num_errors = num_errors + 32'h1;
      finish_test;
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_araddr} = 16'h0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      memData = 16'h0003;
      lateReady = 1'b0;
      {num_errors, checked, memReads} = 96'h0;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rdChk(`OFS_FLAGS, 32'h0, 32'hFFFFFFFF);
      rdChk(`OFS_CORE, 32'h4, 32'hFFFFFFFF);
      check({28'h0, cpuPriorityLevel}, 32'h0);
      wr(`OFS_CORE, 32'h0000FFFF);
      check({30'h0, wrResp}, 32'h0);
      rdChk(`OFS_CORE, 32'h4, 32'hFFFFFFFF);
      s_axi_wstrb <= 4'h1;
      wr(`OFS_CORE, 32'h0);
      s_axi_wstrb <= 4'hF;
      rdChk(`OFS_CORE, 32'h4, 32'hFFFFFFFF);
      lateReady = 1'b1;
      rd(8'h40, d);
      check({30'h0, lastResp}, 32'h2);
      check(d, 32'h0);
      wr(8'h40, 32'h0);
      check({30'h0, wrResp}, 32'h2);
      lateReady = 1'b0;
      alu(16'h0000, 16'h7FFF, 16'h0001, 32'h8000, 32'hFFFFFFFF);
      rdChk(`OFS_FLAGS, 32'h010C, 32'h010F);
      alu(16'h0000, 16'hFFFF, 16'h0001, 32'h0, 32'hFFFFFFFF);
      rdChk(`OFS_FLAGS, 32'h0101, 32'h010D);
      alu(16'h0001, 16'h0000, 16'h0001, 32'hFFFF, 32'hFFFFFFFF);
      rdChk(`OFS_FLAGS, 32'h0008, 32'h010D);
      alu(16'h0001, 16'h0005, 16'h0003, 32'h0002, 32'hFFFFFFFF);
      rdChk(`OFS_FLAGS, 32'h0101, 32'h010D);
      alu(16'h0010, 16'h007F, 16'h0001, 32'h80, 32'hFF);
      rdChk(`OFS_FLAGS, 32'h010C, 32'h010D);
      alu(16'h0002, 16'h00F0, 16'h0F00, 32'h0, 32'hFFFFFFFF);
      rdChk(`OFS_FLAGS, 32'h0002, 32'h000A);
      alu(16'h0000, 16'h0001, 16'h0001, 32'h2, 32'hFFFFFFFF);
      rdChk(`OFS_FLAGS, 32'h0, 32'h0002);
      alu(16'h0003, 16'h00F0, 16'h0F00, 32'h0FF0, 32'hFFFFFFFF);
      alu(16'h0004, 16'h0FF0, 16'h00FF, 32'h0F0F, 32'hFFFFFFFF);
      alu(16'h0005, 16'h8001, 16'h0001, 32'h0002, 32'hFFFFFFFF);
      alu(16'h0006, 16'h8002, 16'h0001, 32'h4001, 32'hFFFFFFFF);
      alu(16'h0007, 16'h8002, 16'h0001, 32'hC001, 32'hFFFFFFFF);
      alu(16'h0020, 16'h0004, 16'h0000, 32'h0007, 32'hFFFFFFFF);
      alu(16'h000A, 16'h0000, 16'h0000, 32'h0003, 32'hFFFFFFFF);
      alu(16'h0008, 16'hFFFF, 16'h0002, 32'hFFFE, 32'hFFFFFFFF);
      rdChk(`OFS_RESHI, 32'hFFFF, 32'hFFFFFFFF);
      alu(16'h0048, 16'hFFFF, 16'h0002, 32'hFFFE, 32'hFFFFFFFF);
      rdChk(`OFS_RESHI, 32'h0001, 32'hFFFFFFFF);
      alu(16'h0088, 16'h0002, 16'hFFFF, 32'hFFFE, 32'hFFFFFFFF);
      rdChk(`OFS_RESHI, 32'hFFFF, 32'hFFFFFFFF);
      alu(16'h0CC8, 16'hFFFF, 16'h0000, 32'hFFFD, 32'hFFFFFFFF);
      rdChk(`OFS_RESHI, 32'hFFFF, 32'hFFFFFFFF);
      alu(16'h0D08, 16'hFFFF, 16'h0000, 32'hFFFD, 32'hFFFFFFFF);
      rdChk(`OFS_RESHI, 32'h0002, 32'hFFFFFFFF);
      alu(16'h0148, 16'h12FF, 16'h34FF, 32'hFE01, 32'hFFFFFFFF);
      rdChk(`OFS_RESHI, 32'h0, 32'hFFFFFFFF);
      divRun(16'h0009, 16'h0064, 16'h0007, 32'h000E, 32'h0002);
      divRun(16'h0209, 16'hFF9C, 16'h0007, 32'hFFF2, 32'hFFFE);
      divRun(16'h0209, 16'h0064, 16'hFFF9, 32'hFFF2, 32'h0002);
      wr(`OFS_CMD, 32'h0009);
      wr(`OFS_STAT, 32'h1);
      rdChk(`OFS_STAT, 32'h0, 32'h1);
      rdChk(`OFS_WREG0, 32'hFFF2, 32'hFFFFFFFF);
      wr(`OFS_CORE, 32'h0);
      rdChk(`OFS_CORE, 32'h0, 32'hFFFFFFFF);
      check({31'h0, windowMapped}, 32'h0);
      wr(`OFS_ADDR, 32'h8000);
      repeat (2) @(posedge clk);
      check({31'h0, addrTrap}, 32'h1);
      rdChk(`OFS_STAT, 32'h2, 32'h2);
      check(memReads, 32'h0);
      wr(`OFS_ADDR, 32'h7FFE);
      repeat (2) @(posedge clk);
      check({31'h0, addrTrap}, 32'h0);
      wr(`OFS_CORE, 32'h4);
      wr(`OFS_ADDR, 32'h9000);
      repeat (2) @(posedge clk);
      check({31'h0, addrTrap}, 32'h0);
      check({16'h0, memAddr}, 32'h9000);
      check(memReads, 32'h2);
      check({31'h0, windowMapped}, 32'h1);
      finish_test;
   end
endmodule // test_cpu_alu_status_multiply
